// ### ees_top.sv
// Serial target with programming registers and EEPROM save and restore.
// Assumes synchronous scl/sda inputs and an EEPROM macro taking one byte per ee_done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "ees_consts.svh"
module ees_top (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  output ees_pkg::ees_nv_req_s     ee,
  input  wire logic                ee_done,
  input  wire logic [7:0]          ee_rdata,
  input  wire logic [7:0]          cfg_addr,
  output logic [7:0]               cfg_data,
  output logic                     nv_busy
);
  ees_pkg::ees_bus_ev_s ev;
  ees_pkg::ees_bit_e    st_q, st_d;
  ees_pkg::ees_nv_e     nv_q, nv_d;
  logic [2:0]           cnt_q, cnt_d;
  logic [7:0]           sh_q, sh_d;
  logic                 got_q, got_d;
  logic [1:0]           bidx_q, bidx_d;
  logic                 rd_q, rd_d;
  logic [7:0]           ptr_q, ptr_d;
  logic                 pend_q, pend_d;
  logic [1:0]           cmd_q, cmd_d;
  logic                 oe_q, oe_d;
  logic [7:0]           nva_q, nva_d;
  logic [7:0]           cfg_q;
  logic                 wr_en;
  logic                 go;
  logic                 busy;
  logic [7:0]           regs [0:255];

  ees_edge u_edge (
    .clock (clock),
    .rst_n (rst_n),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev    (ev)
  );

  assign busy = (nv_q != ees_pkg::NV_IDLE);

  // Byte-level target sequencer; it drives the line only for acknowledge and read data.
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    got_d  = got_q;
    bidx_d = bidx_q;
    rd_d   = rd_q;
    ptr_d  = ptr_q;
    pend_d = pend_q;
    cmd_d  = cmd_q;
    oe_d   = oe_q;
    wr_en  = 1'b0;
    go     = 1'b0;
    if (ev.start) begin
      // A repeated start drops a pending command, since only STOP may launch it.
      st_d   = ees_pkg::ST_RX;
      cnt_d  = `EES_BIT_FIRST;
      got_d  = 1'b0;
      bidx_d = `EES_IDX_ADDR;
      pend_d = 1'b0;
      oe_d   = 1'b0;
    end else if (ev.stop) begin
      st_d   = ees_pkg::ST_IDLE;
      oe_d   = 1'b0;
      got_d  = 1'b0;
      pend_d = 1'b0;
      go     = pend_q & ~busy;
    end else begin
      unique case (st_q)
        ees_pkg::ST_IDLE, ees_pkg::ST_SKIP: begin
          oe_d = 1'b0;
        end
        ees_pkg::ST_RX: begin
          if (ev.scl_rise) begin
            sh_d  = {sh_q[6:0], ev.sda};
            cnt_d = cnt_q + `EES_BIT_STEP;
            got_d = (cnt_q == `EES_BIT_LAST);
          end else if (ev.scl_fall && got_q) begin
            got_d = 1'b0;
            st_d  = ees_pkg::ST_ACK;
            oe_d  = 1'b1;
            if (bidx_q != `EES_IDX_DATA) begin
              bidx_d = bidx_q + `EES_IDX_STEP;
            end
            unique case (bidx_q)
              `EES_IDX_ADDR: begin
                rd_d = sh_q[0];
                // Silence while busy is what lets the master poll for completion.
                if (sh_q[7:1] != `EES_DEV_ADDR || busy) begin
                  st_d = ees_pkg::ST_SKIP;
                  oe_d = 1'b0;
                end
              end
              `EES_IDX_CMD: begin
                cmd_d  = sh_q[1:0];
                pend_d = (sh_q[1:0] == `EES_CMD_SAVE) || (sh_q[1:0] == `EES_CMD_RESTORE);
              end
              `EES_IDX_REG: begin
                if (cmd_q == `EES_CMD_WRITE) begin
                  ptr_d = sh_q;
                end else begin
                  // A save or restore frame carries no third byte.
                  pend_d = 1'b0;
                  st_d   = ees_pkg::ST_SKIP;
                  oe_d   = 1'b0;
                end
              end
              default: begin
                wr_en = 1'b1;
                ptr_d = ptr_q + `EES_REG_STEP;
              end
            endcase
          end
        end
        ees_pkg::ST_ACK: begin
          if (ev.scl_fall) begin
            cnt_d = `EES_BIT_FIRST;
            if (rd_q) begin
              st_d  = ees_pkg::ST_TX;
              sh_d  = regs[ptr_q];
              oe_d  = ~regs[ptr_q][7];
              ptr_d = ptr_q + `EES_REG_STEP;
            end else begin
              st_d = ees_pkg::ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        ees_pkg::ST_TX: begin
          if (ev.scl_rise) begin
            cnt_d = cnt_q + `EES_BIT_STEP;
            got_d = (cnt_q == `EES_BIT_LAST);
          end else if (ev.scl_fall) begin
            if (got_q) begin
              got_d = 1'b0;
              oe_d  = 1'b0;
              st_d  = ees_pkg::ST_TXACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ees_pkg::ST_TXACK: begin
          if (ev.scl_rise) begin
            // A not-acknowledge ends the read; the device then waits for STOP or a repeated start.
            if (ev.sda) begin
              st_d = ees_pkg::ST_SKIP;
            end else begin
              got_d = 1'b1;
            end
          end else if (ev.scl_fall && got_q) begin
            got_d = 1'b0;
            cnt_d = `EES_BIT_FIRST;
            st_d  = ees_pkg::ST_TX;
            sh_d  = regs[ptr_q];
            oe_d  = ~regs[ptr_q][7];
            ptr_d = ptr_q + `EES_REG_STEP;
          end
        end
      endcase
    end
  end

  // Bit sequencer registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ees_pkg::ST_IDLE;
      cnt_q  <= `EES_BIT_FIRST;
      sh_q   <= `EES_REG_FIRST;
      got_q  <= 1'b0;
      bidx_q <= `EES_IDX_ADDR;
      rd_q   <= 1'b0;
      ptr_q  <= `EES_REG_FIRST;
      pend_q <= 1'b0;
      cmd_q  <= `EES_CMD_WRITE;
      oe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      got_q  <= got_d;
      bidx_q <= bidx_d;
      rd_q   <= rd_d;
      ptr_q  <= ptr_d;
      pend_q <= pend_d;
      cmd_q  <= cmd_d;
      oe_q   <= oe_d;
    end
  end

  // Nonvolatile sequencer walks every register address, one byte per ee_done.
  always_comb begin
    nv_d  = nv_q;
    nva_d = nva_q;
    if (go) begin
      nv_d  = (cmd_q == `EES_CMD_SAVE) ? ees_pkg::NV_SAVE : ees_pkg::NV_LOAD;
      nva_d = `EES_REG_FIRST;
    end else if (busy && ee_done) begin
      if (nva_q == `EES_REG_LAST) begin
        nv_d = ees_pkg::NV_IDLE;
      end else begin
        nva_d = nva_q + `EES_REG_STEP;
      end
    end
  end

  // Reset enters the load state so that power-up restores by itself.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nv_q  <= ees_pkg::NV_LOAD;
      nva_q <= `EES_REG_FIRST;
    end else begin
      nv_q  <= nv_d;
      nva_q <= nva_d;
    end
  end

  // Register array; a load and a bus write never meet because the bus is refused while busy.
  always_ff @(posedge clock) begin
    if (nv_q == ees_pkg::NV_LOAD && ee_done) begin
      regs[nva_q] <= ee_rdata;
    end else if (wr_en) begin
      regs[ptr_q] <= sh_q;
    end
  end

  // Read port for the rest of the chip.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `EES_REG_FIRST;
    end else begin
      cfg_q <= regs[cfg_addr];
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe   = oe_q;
  assign ee.req   = busy;
  assign ee.we    = (nv_q == ees_pkg::NV_SAVE);
  assign ee.addr  = nva_q;
  assign ee.wdata = regs[nva_q];
  assign cfg_data = cfg_q;
  assign nv_busy  = busy;
endmodule
`default_nettype wire

// ### ees_consts.svh
// Named constants for the EEPROM save and restore block.
// Assumes that it is included by its bare name wherever the constants are needed.
`ifndef EES_CONSTS_SVH
`define EES_CONSTS_SVH

`define EES_DEV_ADDR    7'h6A
`define EES_CMD_WRITE   2'h0
`define EES_CMD_SAVE    2'h1
`define EES_CMD_RESTORE 2'h2
`define EES_BIT_LAST    3'h7
`define EES_BIT_FIRST   3'h0
`define EES_REG_FIRST   8'h00
`define EES_REG_LAST    8'hFF
`define EES_REG_STEP    8'h01
`define EES_BIT_STEP    3'h1
`define EES_IDX_ADDR    2'h0
`define EES_IDX_CMD     2'h1
`define EES_IDX_REG     2'h2
`define EES_IDX_DATA    2'h3
`define EES_IDX_STEP    2'h1

`endif

// ### ees_pkg.sv
// Types shared by the EEPROM save and restore block.
// Assumes nothing beyond a SystemVerilog compiler.
package ees_pkg;

  // Serial bus events seen in one clock cycle.
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } ees_bus_ev_s;

  // Byte request towards the nonvolatile array.
  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ees_nv_req_s;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_SKIP} ees_bit_e;
  typedef enum logic [1:0] {NV_IDLE, NV_SAVE, NV_LOAD} ees_nv_e;

endpackage

// ### ees_edge.sv
// Serial bus event detector for the EEPROM save and restore block.
// Assumes scl_i and sda_i are already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module ees_edge (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output ees_pkg::ees_bus_ev_s     ev
);
  logic scl_q;
  logic sda_q;

  // Previous line levels; idle bus reads high so reset matches it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // START and STOP are data changes while the clock stays high.
  assign ev.scl_rise = scl_i & ~scl_q;
  assign ev.scl_fall = ~scl_i & scl_q;
  assign ev.start    = scl_i & scl_q & sda_q & ~sda_i;
  assign ev.stop     = scl_i & scl_q & ~sda_q & sda_i;
  assign ev.sda      = sda_i;
endmodule
`default_nettype wire

// ### ees_properties.sv
// Port checks for the save and restore block.
// Assumes one clock domain and the active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ees_props (
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 scl_i,
  input wire logic                 sda_i,
  input wire logic                 sda_oe,
  input wire ees_pkg::ees_nv_req_s ee,
  input wire logic                 ee_done,
  input wire logic                 nv_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // The array walk runs 0 to FF, one byte per done, and keeps the data line free.
  property p_nack; nv_busy |-> !sda_oe; endproperty
  a_nack: assert property (p_nack) else $error("ack while busy");
  property p_go; $rose(nv_busy) |-> scl_i && sda_i; endproperty
  a_go: assert property (p_go) else $error("walk began before stop");
  property p_first; $rose(ee.req) |-> ee.addr == 8'h00; endproperty
  a_first: assert property (p_first) else $error("walk start address");
  property p_step; ee.req && ee_done && ee.addr != 8'hFF |=> ee.addr == $past(ee.addr) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("walk step");
  property p_end; ee.req && ee_done && ee.addr == 8'hFF |=> !ee.req; endproperty
  a_end: assert property (p_end) else $error("walk end");
  property p_hold; ee.req && !ee_done |=> ee.req && $stable(ee.addr) && $stable(ee.we); endproperty
  a_hold: assert property (p_hold) else $error("walk hold");
  property p_ack; $rose(sda_oe) |-> !scl_i; endproperty
  a_ack: assert property (p_ack) else $error("ack with clock high");
  property p_keep; $rose(sda_oe) |-> sda_oe [*2]; endproperty
  a_keep: assert property (p_keep) else $error("ack too short");
  c_save: cover property (nv_busy && ee.we && ee_done);
  c_load: cover property (nv_busy && !ee.we && ee_done);
  c_ack: cover property ($rose(sda_oe));
endmodule
`default_nettype wire

// ### ees_master.sv
// Serial bus master stand-in for the save and restore block.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ees_master (
  input  wire logic clock,
  input  wire logic sda,
  output var logic  scl,
  output var logic  sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Four cycles a level, well above the two-cycle minimum the target needs.
  task automatic half();
    repeat (4) @(negedge clock);
  endtask
  // Start when s is 1, stop when s is 0; a start mid-frame is a repeated start.
  task automatic cond(input logic s);
    sda_low = !s;
    half();
    scl = 1'b1;
    half();
    sda_low = s;
    half();
    scl = !s;
  endtask
  // One byte MSB first, then a ninth bit where nak is driven and ack sampled.
  task automatic xfer(input logic [7:0] b, input logic nak, output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      sda_low = (i < 0) ? !nak : !b[i];
      half();
      scl = 1'b1;
      half();
      if (i >= 0) rd[i] = sda;
      ack = !sda;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### ees_bench.sv
// Self-checking bench for the save and restore block.
// Assumes the master stand-in and a behavioural EEPROM with random latency.
`timescale 1ns/1ps
`default_nettype none
module ees_bench;
  localparam logic [7:0] WADR = 8'hD4;
  logic       clock, rst_n, scl, m_low, ee_done, sda_oe, nv_busy, a, sda_dv;
  logic [7:0] ee_rdata, cfg_addr, cfg_data, r, d;
  logic [7:0] mem [256];
  logic [7:0] mdl [256];
  int         err_count, check_count, seed;
  ees_pkg::ees_nv_req_s ee;
  // Open-drain data line with a pull-up; the device pulls it low only while its drive value is low.
  wire sda = !(m_low | (sda_oe & !sda_dv));
  ees_master mst_u (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));
  ees_top dut_u (.clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_dv), .sda_oe(sda_oe),
    .ee(ee), .ee_done(ee_done), .ee_rdata(ee_rdata), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .nv_busy(nv_busy));
  initial begin
    clock = 1'b0;
    forever #2 clock = !clock;
  end
  // EEPROM stand-in; read data is scrambled outside done cycles.
  always @(negedge clock) begin
    ee_done <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (ee.req && !ee_done && $random(seed) % 2 == 0) begin
      ee_done <= 1'b1;
      ee_rdata <= mem[ee.addr];
      if (ee.we) mem[ee.addr] <= ee.wdata;
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] b);
    mst_u.xfer(b, 1'b1, r, a);
  endtask
  // Address and command bytes, both expected to be acknowledged.
  task automatic cmd(input logic [7:0] c);
    mst_u.cond(1'b1);
    wb(WADR);
    chk("ack", 8'h01, {7'h00, a});
    wb(c);
    chk("ack", 8'h01, {7'h00, a});
  endtask
  // Other traffic keeps off the bus until the walk ends.
  task automatic wait_idle();
    for (int n = 0; n < 4000 && nv_busy !== 1'b0; n++) @(negedge clock);
    chk("nv_busy", 8'h00, {7'h00, nv_busy});
  endtask
  // Every address once, from a random offset so the read address lines see varied patterns.
  task automatic cmp_all();
    logic [7:0] off;
    off = 8'($random(seed));
    for (int k = 0; k < 256; k++) begin
      cfg_addr = 8'(k) ^ off;
      @(negedge clock);
      chk("cfg_data", mdl[cfg_addr], cfg_data);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("wrong value timeout expected done seen hang");
    wrap_up();
  end
  initial begin
    seed = 32'h5BF7286D;
    rst_n = 1'b0;
    ee_done = 1'b0;
    ee_rdata = 8'($random(seed));
    cfg_addr = 8'($random(seed));
    for (int k = 0; k < 256; k++) mem[k] = 8'($random(seed));
    mdl = mem;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    // The address is refused while the power-up load runs.
    mst_u.cond(1'b1);
    wb(WADR);
    chk("ack", 8'h00, {7'h00, a});
    mst_u.cond(1'b0);
    wait_idle();
    cmp_all();
    $display("test powerup done");
    // Writes across the pointer wrap, a foreign address, and a read back.
    cmd(8'hFC);
    wb(8'hFE);
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      mdl[8'(254 + k)] = d;
      wb(d);
      chk("ack", 8'h01, {7'h00, a});
    end
    mst_u.cond(1'b0);
    mst_u.cond(1'b1);
    wb(8'hD6);
    chk("ack", 8'h00, {7'h00, a});
    mst_u.cond(1'b0);
    cmd(8'h00);
    wb(8'hFF);
    mst_u.cond(1'b1);
    wb(8'hD5);
    mst_u.xfer(8'hFF, 1'b0, r, a);
    chk("read", mdl[255], r);
    mst_u.xfer(8'hFF, 1'b1, r, a);
    chk("read", mdl[0], r);
    mst_u.cond(1'b0);
    $display("test frames done");
    // Save waits for stop, then copies everything and refuses the address while the copy runs.
    cmd(8'hFD);
    chk("nv_busy", 8'h00, {7'h00, nv_busy});
    mst_u.cond(1'b0);
    chk("nv_busy", 8'h01, {7'h00, nv_busy});
    mst_u.cond(1'b1);
    wb(WADR);
    chk("ack", 8'h00, {7'h00, a});
    mst_u.cond(1'b0);
    wait_idle();
    for (int k = 0; k < 256; k++) chk("eeprom", mdl[k], mem[k]);
    $display("test save done");
    // Restore of fresh EEPROM contents.
    for (int k = 0; k < 256; k++) mem[k] = 8'($random(seed));
    mdl = mem;
    cmd(8'hA6);
    mst_u.cond(1'b0);
    wait_idle();
    cmp_all();
    $display("test restore done");
    // A bus write dirties one register; a reset in mid-run must bring back the EEPROM contents.
    d = 8'($random(seed));
    cmd(8'h00);
    wb(d);
    wb(~mdl[d]);
    chk("ack", 8'h01, {7'h00, a});
    mst_u.cond(1'b0);
    cfg_addr = d;
    @(negedge clock);
    chk("cfg_data", 8'(~mdl[d]), cfg_data);
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    mst_u.cond(1'b1);
    wb(WADR);
    chk("ack", 8'h00, {7'h00, a});
    mst_u.cond(1'b0);
    wait_idle();
    cmp_all();
    $display("test reset done");
    wrap_up();
  end
endmodule
bind ees_top ees_props chk_u (.clock(clock), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_oe(sda_oe), .ee(ee), .ee_done(ee_done), .nv_busy(nv_busy));
`default_nettype wire
